// File: src/szr_zone_timing.sv
// servo zone recovery, phase detector, locked oscillator counter,
// sector and index generation, register slave on Avalon-MM
// assumes gap and servo bit pins asynchronous to sys_clk_i
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "szr_consts.svh"
module szr_zone_timing #(
    parameter logic [13:0] ZONE_LEN = `SZR_ZONE_LEN
) (
    input  wire logic               sys_clk_i,
    input  wire logic               reset_n_i,
    input  wire logic               gap_i,
    input  wire logic               servo_bit_i,
    input  wire szr_pkg::szr_avs_req_t avs_req_i,
    output      logic [31:0]        avs_readdata_o,
    output      logic               avs_waitrequest_o,
    output      szr_pkg::szr_gates_t gates_o
);
    import szr_pkg::*;

    localparam logic [13:0] ERR_CYC  = 14'(`SZR_ERR_CYC);
    localparam logic [13:0] ZL_LAST  = ZONE_LEN - 14'h0001;
    localparam logic [13:0] HALF     = ZONE_LEN >> 1;
    localparam logic [13:0] WIN_OPEN = ZONE_LEN - `SZR_WIN_PRE;
    localparam logic [13:0] WG_OPEN  = ZONE_LEN - `SZR_WG_PRE;

    szr_state_t q;
    szr_state_t d;

    logic gap_lvl;
    logic bit_lvl;
    logic rise;
    logic running;
    logic wrap;
    logic at_ref;
    logic gwin;
    logic sync_ev;
    logic in_tol;
    logic early;
    logic pump_end;
    logic acc;
    logic [`SZR_TRK_BITS-1:0] bin;

    always_comb begin
        d = q;
        gap_lvl = q.pin[1];
        bit_lvl = q.pin[0];
        rise = q.pin[0] & ~q.pin_p[0];
        running = (q.lk != LK_SEARCH);
        wrap = running && (q.cnt == ZL_LAST);
        // expected sync position: count zero
        at_ref = running && (q.cnt == 14'h0000);
        in_tol = (q.cnt <= ERR_CYC) || (q.cnt >= ZONE_LEN - ERR_CYC);
        early = (q.cnt >= HALF);
        acc = 1'b0;
        pump_end = 1'b0;
        bin = '0;

        // three stage input capture, change taken when stages two and three agree
        d.sy1 = {gap_i, servo_bit_i};
        d.sy2 = q.sy1;
        d.sy3 = q.sy2;
        for (int i = 0; i < 2; i++) begin
            if (q.sy2[i] == q.sy3[i]) begin
                d.pin[i] = q.sy3[i];
            end
        end
        d.pin_p = q.pin;

        // one cycle pulses
        d.g.discharge = 1'b0;
        d.g.write_guard_release_pulse = 1'b0;
        d.g.sector = 1'b0;
        d.g.index = 1'b0;

        // gap search: free while searching or in frequency acquisition mode, windowed otherwise
        gwin = !running || q.frequency_acquire_mode || q.cnt >= WIN_OPEN
               || q.cnt <= ERR_CYC;
        if (gap_lvl && gwin) begin
            if (q.gap_cnt != 8'hFF) begin
                d.gap_cnt = q.gap_cnt + 8'h01;
            end
            if (q.gap_cnt >= `SZR_GAP_MIN - 8'h01) begin
                d.gap_seen = 1'b1;
            end
        end else begin
            d.gap_cnt = 8'h00;
        end
        sync_ev = q.gap_seen && !q.sync_seen && rise && gwin;

        // locked oscillator counter
        if (running) begin
            d.cnt = wrap ? 14'h0000 : q.cnt + 14'h0001;
        end else begin
            d.cnt = 14'h0000;
        end
        if (running && q.cnt == HALF) begin
            d.gap_seen = 1'b0;
            d.sync_seen = 1'b0;
            d.err_big = 1'b0;
        end

        // rephasing
        case (q.lk)
            LK_SEARCH: begin
                if (sync_ev) begin
                    d.lk = LK_WINDOW;
                    d.cnt = 14'h0001;
                end
            end
            LK_WINDOW: begin
                if (sync_ev) begin
                    d.lk = in_tol ? LK_LOCKED : LK_SEARCH;
                end else if (!q.sync_seen && q.cnt == ERR_CYC + 14'h0001) begin
                    d.lk = LK_SEARCH;
                end
            end
            LK_LOCKED: begin
            end
            default: d.lk = LK_SEARCH;
        endcase
        if (sync_ev) begin
            d.sync_seen = 1'b1;
        end
        if (d.lk == LK_SEARCH) begin
            d.gap_seen = d.gap_seen && !q.sync_seen;
            d.sync_seen = 1'b0;
        end

        // phase detector
        case (q.pump)
            PU_IDLE: begin
                if (running && sync_ev && early) begin
                    d.pump = PU_UP;
                    d.err = 14'h0000;
                end else if (at_ref && !sync_ev && !q.sync_seen
                             && (q.gap_seen || q.frequency_acquire_mode)) begin
                    d.pump = PU_DN;
                    d.err = 14'h0000;
                end
            end
            PU_UP, PU_DN: begin
                d.err = q.err + 14'h0001;
                pump_end = (q.pump == PU_UP) ? at_ref
                                             : (sync_ev || q.cnt == HALF);
                if (pump_end) begin
                    d.pump = PU_IDLE;
                    // oversized early error: counter reloaded to time since sync
                    if (q.pump == PU_UP && q.frequency_acquire_mode
                        && q.err_big) begin
                        d.cnt = q.err + 14'h0002;
                        d.g.slow_agc = 1'b1;
                    end
                end else if (q.err == ERR_CYC - 14'h0001) begin
                    d.err_big = 1'b1;
                    if (!q.frequency_acquire_mode) begin
                        d.pump = PU_IDLE;
                    end
                end
            end
            default: d.pump = PU_IDLE;
        endcase
        // acquisition mode resync on an oversized error
        if (q.frequency_acquire_mode && q.err_big && sync_ev && running) begin
            d.cnt = 14'h0001;
            d.g.slow_agc = 1'b1;
            d.pump = PU_IDLE;
        end
        if (!q.frequency_acquire_mode) begin
            d.g.slow_agc = 1'b0;
        end
        d.g.charge_up_pulse = (d.pump == PU_UP);
        d.g.charge_down_pulse = (d.pump == PU_DN);

        // zone timer
        if (sync_ev) begin
            d.zt_run = 1'b1;
            d.zt = 8'h00;
            d.idx_hit = 1'b0;
        end else if (q.zt_run) begin
            d.zt = q.zt + 8'h01;
            if (q.zt >= `SZR_ZT_ADR_S && q.zt < `SZR_ZT_ADR_E
                && q.zt[2:0] == `SZR_BIT_PHASE) begin
                d.trk_sh = {q.trk_sh[`SZR_TRK_BITS-2:0], bit_lvl};
            end
            if (q.zt == `SZR_ZT_ADR_E) begin
                bin[`SZR_TRK_BITS-1] = q.trk_sh[`SZR_TRK_BITS-1];
                for (int i = `SZR_TRK_BITS - 2; i >= 0; i--) begin
                    bin[i] = bin[i+1] ^ q.trk_sh[i];
                end
                d.trk = bin;
            end
            if (q.zt >= `SZR_ZT_IDX_S && q.zt < `SZR_ZT_IDX_E && bit_lvl) begin
                d.idx_hit = 1'b1;
            end
            if (q.zt == `SZR_ZT_END) begin
                d.zt_run = 1'b0;
                d.g.write_guard_release_pulse = !q.err_big
                    && !d.err_big && q.lk == LK_LOCKED;
            end
        end
        d.g.discharge = q.zt_run && q.zt == `SZR_ZT_DIS;
        d.g.agc_gate = q.zt_run && q.zt < `SZR_ZT_AGC_E;
        d.g.address_gate = q.zt_run && q.zt >= `SZR_ZT_ADR_S
                           && q.zt < `SZR_ZT_ADR_E;
        d.g.fine_gate = q.zt_run && q.zt >= `SZR_ZT_FINE_S
                        && q.zt < `SZR_ZT_FINE_E;
        d.g.index_gate = q.zt_run && q.zt >= `SZR_ZT_IDX_S
                         && q.zt < `SZR_ZT_IDX_E;

        // sector counter runs on the counter, not on recovered zones
        if (wrap) begin
            d.sect = q.sect + 5'h01;
            d.g.sector = 1'b1;
            if (q.ix == IX_LOCKED && q.sect == `SZR_SECT_LAST) begin
                d.g.index = 1'b1;
            end
        end

        // index sync, judged at the end of the zone
        if (q.zt_run && q.zt == `SZR_ZT_END && q.idx_hit) begin
            case (q.ix)
                IX_SEARCH: begin
                    d.sect = 5'h00;
                    d.g.index = 1'b1;
                    d.ix = IX_FIRST;
                end
                IX_FIRST: begin
                    d.g.index = 1'b1;
                    if (q.sect == 5'h00) begin
                        d.ix = IX_LOCKED;
                    end else begin
                        d.sect = 5'h00;
                    end
                end
                IX_LOCKED: begin
                    if (q.sect == 5'h00) begin
                        d.cand_v = 1'b0;
                    end else if (q.cand_v && q.cand == q.sect) begin
                        d.sect = 5'h00;
                        d.cand_v = 1'b0;
                    end else begin
                        d.cand = q.sect;
                        d.cand_v = 1'b1;
                    end
                end
                default: d.ix = IX_SEARCH;
            endcase
        end

        // counter decodes for read/write control
        d.g.read_enable = (q.lk == LK_LOCKED) && q.cnt >= `SZR_RD_S
                          && q.cnt < `SZR_RD_E;
        d.g.write_guard_window = (q.lk != LK_LOCKED) || q.cnt >= WG_OPEN
                                 || q.cnt < `SZR_WG_POST;

        // register slave: one wait cycle, then the transfer completes
        acc = (avs_req_i.read || avs_req_i.write) && !q.wait_q;
        d.wait_q = !((avs_req_i.read || avs_req_i.write) && q.wait_q);
        if ((avs_req_i.read || avs_req_i.write) && q.wait_q) begin
            case (avs_req_i.address)
                `SZR_REG_CTRL:
                    d.rdata = {31'h0, q.frequency_acquire_mode};
                `SZR_REG_STAT:
                    d.rdata = {21'h0, q.err_big, q.g.slow_agc, q.sect,
                               q.ix, q.lk};
                `SZR_REG_TRACK:
                    d.rdata = {20'h0, q.trk};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        if (acc && avs_req_i.write && avs_req_i.address == `SZR_REG_CTRL
            && avs_req_i.byteenable[0]) begin
            d.frequency_acquire_mode =
                avs_req_i.writedata[`SZR_CTRL_FREQ];
            if (avs_req_i.writedata[`SZR_CTRL_RESYNC]) begin
                d.lk = LK_SEARCH;
                d.ix = IX_SEARCH;
                d.cand_v = 1'b0;
                d.pump = PU_IDLE;
                d.gap_seen = 1'b0;
                d.sync_seen = 1'b0;
                d.zt_run = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
            q.lk <= LK_SEARCH;
            q.ix <= IX_SEARCH;
            q.pump <= PU_IDLE;
            q.wait_q <= 1'b1;
            q.g.write_guard_window <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.wait_q;
    assign gates_o = q.g;
endmodule

// File: include/szr_consts.svh
// constants for the servo zone recovery and timing block
// assumes one servo-derived system clock of 4 ns
`ifndef SZR_CONSTS_SVH
`define SZR_CONSTS_SVH

// clock and phase error limit
`define SZR_CLK_NS      16'h0004
`define SZR_ERR_NS      16'h0320
`define SZR_ERR_CYC     (`SZR_ERR_NS / `SZR_CLK_NS)

// locked oscillator counter span per zone
`define SZR_ZONE_LEN    14'h2860
// gap search window opens this many counts before the expected sync
`define SZR_WIN_PRE     14'h0258
// least gap length in cycles
`define SZR_GAP_MIN     8'h28

// zone timer decodes, cycles after the sync bit
`define SZR_ZT_AGC_E    8'h30
`define SZR_ZT_ADR_S    8'h30
`define SZR_ZT_ADR_E    8'h90
`define SZR_ZT_DIS      8'h90
`define SZR_ZT_FINE_S   8'h92
`define SZR_ZT_FINE_E   8'hD2
`define SZR_ZT_IDX_S    8'hD2
`define SZR_ZT_IDX_E    8'hE2
`define SZR_ZT_END      8'hE6
`define SZR_BIT_PHASE   3'h4
`define SZR_TRK_BITS    12

// read enable and write guard decodes of the zone counter
`define SZR_RD_S        14'h0200
`define SZR_RD_E        14'h2600
`define SZR_WG_PRE      14'h0100
`define SZR_WG_POST     14'h0180

// last sector number of a revolution, 32 sectors per revolution
`define SZR_SECT_LAST   5'h1F

// register map, byte addresses
`define SZR_REG_CTRL    4'h0
`define SZR_REG_STAT    4'h4
`define SZR_REG_TRACK   4'h8
`define SZR_CTRL_FREQ   0
`define SZR_CTRL_RESYNC 1

`endif

// File: include/szr_pkg.sv
// types for the servo zone recovery and timing block
// relies on szr_consts.svh for the track bit width only
package szr_pkg;
    `include "szr_consts.svh"

    typedef enum logic [1:0] {LK_SEARCH, LK_WINDOW, LK_LOCKED} szr_lock_t;
    typedef enum logic [1:0] {IX_SEARCH, IX_FIRST, IX_LOCKED} szr_index_t;
    typedef enum logic [1:0] {PU_IDLE, PU_UP, PU_DN} szr_pump_t;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } szr_avs_req_t;

    typedef struct packed {
        logic charge_up_pulse;
        logic charge_down_pulse;
        logic agc_gate;
        logic address_gate;
        logic discharge;
        logic fine_gate;
        logic index_gate;
        logic write_guard_release_pulse;
        logic slow_agc;
        logic sector;
        logic index;
        logic read_enable;
        logic write_guard_window;
    } szr_gates_t;

    typedef struct packed {
        logic [1:0]                sy1;
        logic [1:0]                sy2;
        logic [1:0]                sy3;
        logic [1:0]                pin;
        logic [1:0]                pin_p;
        szr_lock_t                 lk;
        logic [13:0]               cnt;
        logic [7:0]                gap_cnt;
        logic                      gap_seen;
        logic                      sync_seen;
        szr_pump_t                 pump;
        logic [13:0]               err;
        logic                      err_big;
        logic                      zt_run;
        logic [7:0]                zt;
        logic [`SZR_TRK_BITS-1:0]  trk_sh;
        logic [`SZR_TRK_BITS-1:0]  trk;
        szr_index_t                ix;
        logic [4:0]                sect;
        logic [4:0]                cand;
        logic                      cand_v;
        logic                      idx_hit;
        logic                      frequency_acquire_mode;
        logic                      wait_q;
        logic [31:0]               rdata;
        szr_gates_t                g;
    } szr_state_t;
endpackage

// File: tb/szr_zone_timing_properties.sv
// port-level checker for szr_zone_timing
// bound from the testbench top; sees only the block's ports
`timescale 1ns/1ps
module szr_zone_timing_properties #(
    parameter logic [13:0] ZONE_LEN = 14'h2860
) (
    input wire logic                  sys_clk_i,
    input wire logic                  reset_n_i,
    input wire logic                  gap_i,
    input wire logic                  servo_bit_i,
    input wire szr_pkg::szr_avs_req_t avs_req_i,
    input wire logic [31:0]           avs_readdata_o,
    input wire logic                  avs_waitrequest_o,
    input wire szr_pkg::szr_gates_t   gates_o
);
    import szr_pkg::*;
    localparam int ERR_CYC = 200;
    logic        freq_q;
    logic [15:0] up_q;
    logic [15:0] dn_q;
    logic [15:0] gap_q;

    // mirror of the mode bit, pump run lengths, cycles since a gap
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            freq_q <= 1'h0;
            up_q   <= 16'h0000;
            dn_q   <= 16'h0000;
            gap_q  <= 16'hFFFF;
        end else begin
            if (avs_req_i.write && !avs_waitrequest_o &&
                avs_req_i.address == 4'h0 && avs_req_i.byteenable[0])
                freq_q <= avs_req_i.writedata[0];
            up_q <= gates_o.charge_up_pulse ? up_q + 16'h0001 : 16'h0000;
            dn_q <= gates_o.charge_down_pulse ? dn_q + 16'h0001 : 16'h0000;
            if (gap_i)
                gap_q <= 16'h0000;
            else if (gap_q != 16'hFFFF)
                gap_q <= gap_q + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_ack;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    sequence s_discharge;
        gates_o.discharge ##1 !gates_o.discharge;
    endsequence

    property p_bus_wait;
        (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> s_ack;
    endproperty
    property p_pump_excl;
        !(gates_o.charge_up_pulse && gates_o.charge_down_pulse);
    endproperty
    property p_clamp;
        !freq_q |-> up_q <= ERR_CYC && dn_q <= ERR_CYC;
    endproperty
    property p_down_gap;
        $rose(gates_o.charge_down_pulse) && !freq_q |->
            gap_q < 16'(ZONE_LEN);
    endproperty
    property p_agc_addr;
        $fell(gates_o.agc_gate) |-> gates_o.address_gate;
    endproperty
    property p_discharge;
        $fell(gates_o.address_gate) |-> s_discharge;
    endproperty
    property p_fine_index;
        $fell(gates_o.fine_gate) |-> gates_o.index_gate;
    endproperty
    property p_sector;
        gates_o.sector |=> !gates_o.sector [*8];
    endproperty

    a_bus_wait: assert property (p_bus_wait)
        else $error("bus answer not after one wait cycle");
    a_pump_excl: assert property (p_pump_excl)
        else $error("both charge pumps high");
    a_clamp: assert property (p_clamp)
        else $error("charge pulse longer than limit");
    a_down_gap: assert property (p_down_gap)
        else $error("charge down without a gap");
    a_agc_addr: assert property (p_agc_addr)
        else $error("address gate not after gain gate");
    a_discharge: assert property (p_discharge)
        else $error("discharge pulse missing");
    a_fine_index: assert property (p_fine_index)
        else $error("index gate not after fine gate");
    a_sector: assert property (p_sector)
        else $error("sector pulses too close");
endmodule

// File: tb/szr_servo_head.sv
// servo head and demodulator model: gap, sync bit, gray track bits
// one zone every P cycles, each zone lengthened by the adj_i value taken when the previous zone ends
`timescale 1ns/1ps
module szr_servo_head #(
    parameter int P = 1400
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               en_i,
    input  wire logic               gap_en_i,
    input  wire logic signed [15:0] adj_i,
    input  wire logic [11:0]        track_i,
    output      logic               gap_o,
    output      logic               servo_bit_o,
    output      logic               zone_o
);
    logic [15:0] pc_q;
    logic [15:0] len_q;
    logic [15:0] z;
    logic [11:0] gray;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_q  <= 16'h0000;
            len_q <= 16'(P);
        end else if (en_i) begin
            if (pc_q == len_q - 16'h0001) begin
                pc_q  <= 16'h0000;
                len_q <= 16'(P + int'(adj_i));
            end else begin
                pc_q <= pc_q + 16'h0001;
            end
        end
    end

    // gap 45 cycles, sync bit two cycles later, then 8-cycle track slots
    always_comb begin
        gray        = track_i ^ (track_i >> 1);
        z           = pc_q - 16'h002F;
        gap_o       = en_i && gap_en_i && pc_q < 16'h002D;
        servo_bit_o = en_i && (pc_q == 16'h002F || pc_q == 16'h0030);
        if (en_i && z >= 16'h0030 && z < 16'h0090)
            servo_bit_o = gray[17 - int'(z[7:3])];
        zone_o      = en_i && pc_q == 16'(P / 2);
    end
endmodule

// File: tb/szr_zone_timing_tb.sv
// testbench for szr_zone_timing: bus master tasks and scenarios
// a servo head model drives the gap and servo bit pins
`timescale 1ns/1ps
module szr_zone_timing_tb;
    import szr_pkg::*;
    localparam int ZN = 1400;
    logic               sys_clk_i;
    logic               reset_n_i;
    logic               en;
    logic               gap_en;
    logic signed [15:0] adj;
    logic               gap;
    logic               sbit;
    logic               zone;
    szr_avs_req_t       req;
    logic [31:0]        rdata;
    logic [31:0]        q;
    logic               wreq;
    szr_gates_t         g;
    int                 mismatches;
    int                 n_tests;
    int                 cyc;

    szr_zone_timing #(.ZONE_LEN(14'(ZN))) u_szr_zone_timing (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .gap_i(gap),
        .servo_bit_i(sbit), .avs_req_i(req), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .gates_o(g));
    szr_servo_head #(.P(ZN)) u_szr_servo_head (
        .clk_i(sys_clk_i), .rst_n_i(reset_n_i), .en_i(en),
        .gap_en_i(gap_en), .adj_i(adj), .track_i(12'hA5C),
        .gap_o(gap), .servo_bit_o(sbit), .zone_o(zone));

    initial begin
        sys_clk_i = 1'h0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            test_done();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", nm, e, s);
        end
    endtask

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        req <= '{address: a, read: !w, write: w, writedata: d,
                 byteenable: 4'hF};
        do @(posedge sys_clk_i); while (wreq !== 1'h0);
        q = rdata;
        req.read <= 1'h0;
        req.write <= 1'h0;
        @(posedge sys_clk_i);
    endtask

    task wz;
        do @(posedge sys_clk_i); while (zone !== 1'h1);
    endtask

    // one head zone is lengthened by k, so later syncs come k late
    task shift(input int k);
        wz();
        adj <= 16'(k);
        wz();
        adj <= 16'h0000;
    endtask

    task measure(input int eu, input int ed, input int er);
        int u, d, r, s;
        u = 0;
        d = 0;
        r = 0;
        s = 0;
        repeat (ZN) begin
            @(posedge sys_clk_i);
            u += int'(g.charge_up_pulse === 1'h1);
            d += int'(g.charge_down_pulse === 1'h1);
            r += int'(g.write_guard_release_pulse === 1'h1);
            s += int'(g.sector === 1'h1);
        end
        chk("charge up", eu, u);
        chk("charge down", ed, d);
        chk("release", er, r);
        chk("sector", 1, s);
    endtask

    task t_reset;
        chk("waitrequest", 1, wreq);
        chk("gates", 32'h1, {19'h0, g});
        bus(1'h0, 4'h4, 32'h0);
        chk("status", 0, q);
        bus(1'h0, 4'hC, 32'h0);
        chk("unmapped", 0, q);
        bus(1'h1, 4'h0, 32'h1);
        bus(1'h0, 4'h0, 32'h0);
        chk("control", 1, q);
        bus(1'h1, 4'h0, 32'h0);
        $display("reset test done");
    endtask

    task t_lock;
        bus(1'h1, 4'h0, 32'h2);
        en <= 1'h1;
        repeat (6) begin
            wz();
            bus(1'h0, 4'h4, 32'h0);
            if (q[1:0] === 2'h2)
                break;
        end
        chk("lock", 2, q[1:0]);
        bus(1'h0, 4'h8, 32'h0);
        chk("track", 32'hA5C, q);
        wz();
        measure(0, 0, 1);
        $display("lock test done");
    endtask

    task t_phase;
        shift(-50);
        measure(50, 0, 1);
        shift(50);
        shift(6);
        measure(0, 6, 1);
        gap_en <= 1'h0;
        measure(0, 0, 0);
        gap_en <= 1'h1;
        shift(-6);
        shift(-300);
        measure(200, 0, 0);
        $display("phase test done");
    endtask

    task t_freq;
        wz();
        bus(1'h1, 4'h0, 32'h1);
        measure(300, 0, 0);
        wz();
        wz();
        chk("slow gain", 1, g.slow_agc);
        bus(1'h1, 4'h0, 32'h0);
        repeat (2) @(posedge sys_clk_i);
        chk("slow gain off", 0, g.slow_agc);
        wz();
        measure(0, 0, 1);
        $display("frequency test done");
    endtask

    initial begin
        reset_n_i = 1'h0;
        en = 1'h0;
        gap_en = 1'h1;
        adj = 16'h0000;
        req = '0;
        cyc = 0;
        mismatches = 0;
        n_tests = 0;
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'h1;
        @(posedge sys_clk_i);
        t_reset();
        t_lock();
        t_phase();
        t_freq();
        test_done();
    end
endmodule

bind szr_zone_timing szr_zone_timing_properties #(.ZONE_LEN(ZONE_LEN))
    u_szr_zone_timing_properties (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .gap_i(gap_i),
    .servo_bit_i(servo_bit_i), .avs_req_i(avs_req_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .gates_o(gates_o));
